// ===== sim/lpc_laser_ctrl_asserts.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checks of the laser power control core.
module lpc_laser_ctrl_asserts import lpc_pkg::*; #(parameter int BIAS_W = 12) (
  // Clock, reset and bus pins.
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  scl,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  input wire logic                  module_select_n,
  // Converter, loop and drives.
  input wire lpc_pkg::lpc_adc_req_s adc_req,
  input wire lpc_pkg::lpc_adc_rsp_s adc_rsp,
  input wire logic [9:0]            photodiode_feedback,
  input wire logic [BIAS_W-1:0]     bias_drive,
  input wire logic                  feedback_direction,
  input wire logic [7:0]            modulation_drive,
  input wire logic [2:0]            modulation_range,
  input wire logic                  interrupt_out,
  input wire logic                  interrupt_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A slow loop protects the laser from current steps.
  a_bias_step: assert property ($changed(bias_drive) |->
    bias_drive == $past(bias_drive) + 1'b1 || bias_drive == $past(bias_drive) - 1'b1) else $error("bias jump");
  a_bias_pace: assert property ($changed(bias_drive) |=> $stable(bias_drive)[*8])
    else $error("bias moves too fast");
  a_ramp_zero: assert property ($fell(rst) |-> bias_drive == '0 && modulation_drive == 8'h00)
    else $error("drives not zero after reset");
  a_range_top: assert property (modulation_range <= 3'h4)
    else $error("range code above top");
  a_start_hold: assert property (adc_req.start |=> !adc_req.start && $stable(adc_req.chan))
    else $error("conversion request repeated");
  a_chan_legal: assert property (adc_req.start |-> adc_req.chan <= MON_AUX2)
    else $error("unknown channel requested");
  a_desel_quiet: assert property ($rose(sda_oe) |-> !$past(module_select_n) && !sda_out)
    else $error("data line driven while deselected");
  a_int_drain: assert property (!interrupt_out)
    else $error("interrupt pin driven high");
  // Main scenarios.
  c_aux2_done: cover property (adc_rsp.done && adc_req.chan == MON_AUX2);
  c_ack: cover property ($rose(sda_oe));
  c_mod_move: cover property ($changed(modulation_drive));
endmodule

bind lpc_laser_ctrl lpc_laser_ctrl_asserts #(.BIAS_W(BIAS_W)) u_chk (.*);

// ===== sim/lpc_laser_ctrl_bench.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench of the laser power control core.
module lpc_laser_ctrl_bench;
  import lpc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, scl = 1'b1, sdm = 1'b1, msel_n = 1'b0, ok, rail_seen = 1'b0;
  logic [12:0] temp_code = 13'h0000;
  logic [3:0] slow = 4'h1;
  logic [7:0] tbl [int];
  logic [7:0] rv, mod, e;
  logic [11:0] bias;
  logic [9:0] pd;
  logic [2:0] range;
  logic sda_out, sda_oe, fb_dir, int_out, int_oe;
  lpc_adc_req_s adc_req;
  lpc_adc_rsp_s adc_rsp;
  int failures = 0, compares = 0, seed = 32'hdc01, sup_seen = 0, n0;
  int tl[7] = '{-50, -40, -37, 0, 101, 102, 120};
  wire sda_in = sdm & ~sda_oe;
  // Clock and supply channel watch.
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (adc_rsp.done && adc_req.chan == MON_SUPPLY) begin
    sup_seen++;
    rail_seen <= adc_req.rail;
  end
  lpc_laser_ctrl #(.SAVED_APC_COARSE(8'h03)) i_dut (.mclk, .rst, .scl, .sda_in, .sda_out, .sda_oe,
    .module_select_n(msel_n), .adc_req, .adc_rsp, .photodiode_feedback(pd), .bias_drive(bias),
    .feedback_direction(fb_dir), .modulation_drive(mod), .modulation_range(range),
    .interrupt_out(int_out), .interrupt_oe(int_oe));
  lpc_partner i_far (.mclk, .rst, .temp_code, .slow, .adc_req, .bias_drive(bias), .adc_rsp,
    .photodiode_feedback(pd));
  // Bus cycles, waits and comparisons.
  task automatic pin(input logic c, input logic d);
    @(posedge mclk);
    scl <= c;
    sdm <= d;
    repeat (9) @(posedge mclk);
  endtask
  task automatic bitx(input logic b, output logic s);
    pin(1'b0, b);
    pin(1'b1, b);
    s = sda_in;
    pin(1'b0, b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(m, a);
  endtask
  task automatic cond(input logic s);
    pin(s, s);
    pin(1'b1, 1'b0);
    pin(!s, !s);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic a);
    logic [7:0] q;
    logic a0, a1;
    cond(1'b1);
    xfer(8'ha0, 1'b1, q, a0);
    xfer(r, 1'b1, q, a1);
    xfer(d, 1'b1, q, a);
    a = a | a0 | a1;
    cond(1'b0);
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] q);
    logic a;
    cond(1'b1);
    xfer(8'ha0, 1'b1, q, a);
    xfer(r, 1'b1, q, a);
    cond(1'b0);
    cond(1'b1);
    xfer(8'ha1, 1'b1, q, a);
    xfer(8'hff, 1'b1, q, a);
    cond(1'b0);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic await(input bit sel, input logic [11:0] x);
    int n;
    n = 0;
    while ((sel ? bias : {4'h0, mod}) !== x && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 9000) begin
      failures++;
      stop_test;
    end
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Model of the table address for a whole-degree temperature.
  function automatic logic [7:0] idx(input int deg);
    if (deg <= -40) return 8'h80;
    if (deg >= 102) return 8'hc7;
    return 8'(128 + (deg + 40) / 2);
  endfunction
  task automatic put(input logic [7:0] a);
    do tbl[a] = 8'($random(seed)); while (tbl[a] == mod);
    wr(8'he0, a - 8'h80, ok);
    wr(8'he1, tbl[a], ok);
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    check(bias, 12'h000);
    rd(8'hb2, rv);
    check(rv, 8'h03);
    foreach (tl[i]) begin
      e = idx(tl[i]);
      if (!tbl.exists(e)) put(e);
      slow <= 4'($random(seed)) & 4'h7;
      temp_code <= 13'(tl[i] * 32);
      await(1'b0, {4'h0, tbl[e]});
      check(mod, tbl[e]);
      rd(8'hb0, rv);
      check(rv, e);
    end
    wr(8'hb2, 8'h00, ok);
    wr(8'hb1, 8'h3c, ok);
    temp_code <= 13'h0000;
    await(1'b0, 12'h03c);
    repeat (1500) @(posedge mclk);
    rd(8'hb0, rv);
    check(rv, 8'hc7);
    wr(8'hb2, 8'h01, ok);
    wr(8'hb1, 8'h77, ok);
    repeat (1500) @(posedge mclk);
    rd(8'hb0, rv);
    check(rv, idx(0));
    check(mod, 8'h77);
    wr(8'hb2, 8'h02, ok);
    wr(8'hb0, 8'h81, ok);
    await(1'b0, {4'h0, tbl[8'h81]});
    check(mod, tbl[8'h81]);
    for (int c = 0; c < 8; c++) begin
      wr(8'h86, 8'(c), ok);
      check(range, (c > 4) ? 3'h4 : 3'(c));
    end
    msel_n <= 1'b1;
    wr(8'h86, 8'h02, ok);
    check({ok, range}, 4'hc);
    msel_n <= 1'b0;
    put(idx(32));
    wr(8'hb2, 8'h03, ok);
    temp_code <= 13'h1060;
    await(1'b0, {4'h0, tbl[8'h80]});
    rd(8'h60, rv);
    check(rv, 8'h88);
    wr(8'h8b, 8'h0f, ok);
    await(1'b0, {4'h0, tbl[idx(32)]});
    check(mod, tbl[idx(32)]);
    rd(8'h60, rv);
    check(rv, 8'hd8);
    wr(8'h8b, 8'h0c, ok);
    repeat (800) @(posedge mclk);
    n0 = sup_seen;
    repeat (1500) @(posedge mclk);
    check(16'(sup_seen - n0), 16'h0000);
    rd(8'h62, rv);
    check(rv, 8'h00);
    wr(8'hdc, 8'h01, ok);
    wr(8'h8b, 8'h0d, ok);
    wr(8'he3, 8'h30, ok);
    repeat (1500) @(posedge mclk);
    check(rail_seen, 1'b1);
    check(int_oe, 1'b1);
    check(bias, 12'h00c);
    wr(8'h84, 8'h04, ok);
    wr(8'h85, 8'h81, ok);
    await(1'b1, 12'd17);
    check(fb_dir, 1'b1);
    repeat (1000) @(posedge mclk);
    check(bias, 12'd17);
    stop_test;
  end
endmodule

// ===== sim/lpc_partner.sv
`timescale 1ns/10ps
// ==========================================================================
// Converter front end and photodiode as seen by the core.
module lpc_partner import lpc_pkg::*; (
  // Clock, reset and bench controls.
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic [12:0]           temp_code,
  input wire logic [3:0]            slow,
  // Core side.
  input wire lpc_pkg::lpc_adc_req_s adc_req,
  input wire logic [11:0]           bias_drive,
  output lpc_pkg::lpc_adc_rsp_s     adc_rsp,
  output logic [9:0]                photodiode_feedback
);
  logic       done_reg, run_reg;
  logic [3:0] wait_reg;
  // Each conversion ends after the delay the bench asks for.
  always_ff @(posedge mclk) begin
    done_reg <= 1'b0;
    if (rst || adc_req.start) begin
      run_reg  <= !rst;
      wait_reg <= slow;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else begin
      done_reg <= run_reg;
      run_reg  <= 1'b0;
    end
  end
  // Temperature gives the bench value; other channels a fixed 400h level, data scrambled between results.
  assign adc_rsp = '{done: done_reg, data: !done_reg ? ~temp_code : (adc_req.chan == MON_TEMP) ? temp_code : 13'h0400};
  // Photodiode current follows the bias drive with unit gain.
  assign photodiode_feedback = bias_drive[9:0];
endmodule

// ===== src/lpc_laser_ctrl.sv
`timescale 1ns/10ps
`include "lpc_regs.svh"

// Overview of operation
// - Feedback target is 5.859uA per coarse step plus 1.464uA per fine step.
// - Direction bit 0 selects sink mode near 1.2V, 1 source mode near 2.0V.
// - Bias drive keeps adjusting until measured feedback matches target, and re-corrects.
// - At start-up the target ramps up to the saved setting.
// - Range codes 000 to 100 select 75, 150, 300, 600, 1200uA full scale.
// - Modulation code has 256 steps including zero; FFh is full scale.
// - Table holds 8-bit values, one per 2 degree slot, -40 to +102 degrees.
// - At or below -40 indexes 80h, each 2 degrees adds one, +102 up gives C7h.
// - Index enable and automatic-value enable both set after reset.
// - Both clear: software writes value directly, pointer frozen and unused.
// - Index clear, auto set: software writes value, pointer tracks temperature only.
// - Index set, auto clear: software writes pointer, value loads from that entry.
// - Automatic: pointer follows temperature, value copies entry, drives modulation.
// - Channels convert in a repeating round robin, each refreshed once per frame.
// - Results are 16 bits of 13-bit resolution, unsigned except two's complement temperature.
// - Results average eight conversions, internal temperature sixteen.
// - Both auxiliary channels and supply can leave the sequence; the rest always stay.
// - Source bit set lets second auxiliary index the table; internal temperature keeps running.
// - Internal temperature clamps -40/+103.9375 with external source, else -120/+127.96875.
// - Second auxiliary has its own out-of-tolerance flag driving the interrupt output while the source bit is clear.
// - Supply enable clear gives no supply result; rail bit picks 3.3V/5V or 1.8V.
module lpc_laser_ctrl #(
  parameter logic [6:0] DEV_ADDR   = 7'h50,
  parameter int         BIAS_W     = 12,
  parameter logic [7:0] SAVED_APC_COARSE = 8'h00,
  parameter logic [1:0] SAVED_APC_FINE = 2'h0
) (
  // Clock and reset.
  input  wire  logic                 mclk,
  input  wire  logic                 rst,
  // Two-wire serial bus pins.
  input  wire  logic                 scl,
  input  wire  logic                 sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire  logic                 module_select_n,
  // Converter front end.
  output lpc_pkg::lpc_adc_req_s      adc_req,
  input  wire  lpc_pkg::lpc_adc_rsp_s adc_rsp,
  // Bias power loop.
  input  wire  logic [9:0]           photodiode_feedback,
  output logic [BIAS_W-1:0]          bias_drive,
  output logic                       feedback_direction,
  // Modulation drive.
  output logic [7:0]                 modulation_drive,
  output logic [2:0]                 modulation_range,
  // Interrupt pin, open drain.
  output logic                       interrupt_out,
  output logic                       interrupt_oe
);
  import lpc_pkg::*;

  localparam int TICK_CYC = (`LPC_APC_TICK_CYCLES < 1) ? 1 : `LPC_APC_TICK_CYCLES;

  // ========================================================================
  // Decoding helpers.

  // Table address from a signed whole-degree temperature.
  function automatic logic [7:0] temp_to_index(input logic signed [7:0] deg);
    logic signed [9:0] off;
    off = 10'(deg) - 10'(`LPC_TEMP_MIN_DEG);
    if (deg <= 8'(`LPC_TEMP_MIN_DEG)) begin
      temp_to_index = `LPC_TBL_FIRST;
    end else if (deg >= 8'(`LPC_TEMP_MAX_DEG)) begin
      temp_to_index = `LPC_TBL_LAST;
    end else begin
      temp_to_index = `LPC_TBL_FIRST + 8'(off >>> 1);
    end
  endfunction

  // Next enabled channel after the current one.
  function automatic lpc_chan_e next_chan(input lpc_chan_e c, input logic [7:0] en);
    lpc_chan_e n;
    n = c;
    for (int i = 0; i < 7; i++) begin
      n = (n == MON_AUX2) ? MON_TEMP : lpc_chan_e'(n + 3'h1);
      if ((n == MON_SUPPLY && !en[`LPC_BIT_SUPPLY_EN]) || (n == MON_AUX1 && !en[`LPC_BIT_AUX1_EN]) ||
          (n == MON_AUX2 && !en[`LPC_BIT_AUX2_EN])) begin
        continue;
      end
      break;
    end
    next_chan = n;
  endfunction

  // ========================================================================
  // Registers and storage.
  logic [7:0]  apc_coarse_reg, apc_fine_reg, range_reg, src_supply_reg;
  logic [7:0]  pointer_reg, value_reg, mode_reg, rail_reg;
  logic [7:0]  tbl_waddr_reg, aux2_high_reg, aux2_low_reg;
  logic [7:0]  lut_mem [128];
  logic [15:0] result_reg [7];
  logic        aux2_flag_reg;

  // Serial bus state.
  logic [2:0]    pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg, pin_q_reg;
  lpc_tw_state_e tw_state_reg;
  logic [7:0]    tw_shift_reg, tw_ptr_reg;
  logic [3:0]    tw_cnt_reg;
  logic          tw_rw_reg, tw_first_reg, tw_low_reg;
  logic          scl_rise, scl_fall, bus_start, bus_stop, desel;
  logic          wr_stb;
  logic [7:0]    wr_addr, rd_byte;

  // ========================================================================
  // Pin synchronisers: a change counts once the second and third stages agree.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      pin_s3_reg <= 3'h7;
      pin_f_reg  <= 3'h7;
      pin_q_reg  <= 3'h7;
    end else begin
      pin_s1_reg <= {module_select_n, scl, sda_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_f_reg  <= (pin_s2_reg & pin_s3_reg) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
      pin_q_reg  <= pin_f_reg;
    end
  end

  // Bus events from the filtered pins.
  assign scl_rise  = pin_f_reg[1] & ~pin_q_reg[1];
  assign scl_fall  = ~pin_f_reg[1] & pin_q_reg[1];
  assign bus_start = pin_f_reg[1] & pin_q_reg[1] & pin_q_reg[0] & ~pin_f_reg[0];
  assign bus_stop  = pin_f_reg[1] & pin_q_reg[1] & ~pin_q_reg[0] & pin_f_reg[0];
  assign desel     = pin_f_reg[2];
  assign wr_stb    = scl_fall & (tw_state_reg == TW_WRITE) & (tw_cnt_reg == 4'h8) & ~tw_first_reg;
  assign wr_addr   = tw_ptr_reg;

  // Read data multiplexer.
  always_comb begin
    rd_byte = 8'h00;
    if (tw_ptr_reg >= `LPC_OFF_RESULT_BASE && tw_ptr_reg < `LPC_OFF_RESULT_BASE + 8'he) begin
      rd_byte = tw_ptr_reg[0] ? result_reg[3'(tw_ptr_reg[3:1])][7:0] : result_reg[3'(tw_ptr_reg[3:1])][15:8];
    end else if (tw_ptr_reg >= `LPC_TBL_FIRST && tw_ptr_reg <= 8'hff && tw_ptr_reg == `LPC_OFF_TBL_WDATA) begin
      rd_byte = lut_mem[tbl_waddr_reg[6:0]];
    end else begin
      unique case (tw_ptr_reg)
        `LPC_OFF_APC_COARSE:  rd_byte = apc_coarse_reg;
        `LPC_OFF_APC_FINE:    rd_byte = apc_fine_reg;
        `LPC_OFF_MOD_RANGE:   rd_byte = range_reg;
        `LPC_OFF_SRC_SUPPLY:  rd_byte = src_supply_reg;
        `LPC_OFF_TBL_POINTER: rd_byte = pointer_reg;
        `LPC_OFF_TBL_VALUE:   rd_byte = value_reg;
        `LPC_OFF_TBL_MODE:    rd_byte = mode_reg;
        `LPC_OFF_RAIL_SEL:    rd_byte = rail_reg;
        `LPC_OFF_TBL_WADDR:   rd_byte = tbl_waddr_reg;
        `LPC_OFF_AUX2_HIGH:   rd_byte = aux2_high_reg;
        `LPC_OFF_AUX2_LOW:    rd_byte = aux2_low_reg;
        `LPC_OFF_FLAGS:       rd_byte = {7'h00, aux2_flag_reg};
        default:              rd_byte = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // Serial slave: address, register pointer, writes and auto-incrementing reads.
  always_ff @(posedge mclk) begin
    if (rst || desel || bus_stop) begin
      tw_state_reg <= TW_IDLE;
      tw_low_reg   <= 1'b0;
      tw_cnt_reg   <= 4'h0;
      tw_shift_reg <= 8'h00;
      tw_rw_reg    <= 1'b0;
      tw_first_reg <= 1'b1;
      if (rst) begin
        tw_ptr_reg <= 8'h00;
      end
    end else if (bus_start) begin
      tw_state_reg <= TW_ADDR;
      tw_low_reg   <= 1'b0;
      tw_cnt_reg   <= 4'h0;
      tw_first_reg <= 1'b1;
    end else if (scl_rise) begin
      if (tw_state_reg == TW_ADDR || tw_state_reg == TW_WRITE) begin
        tw_shift_reg <= {tw_shift_reg[6:0], pin_f_reg[0]};
        tw_cnt_reg   <= tw_cnt_reg + 4'h1;
      end else if (tw_state_reg == TW_RACK) begin
        tw_rw_reg <= ~pin_f_reg[0]; // Keep reading only on acknowledge.
      end
    end else if (scl_fall) begin
      unique case (tw_state_reg)
        TW_IDLE: begin
          tw_low_reg <= 1'b0;
        end
        TW_ADDR: begin
          if (tw_cnt_reg == 4'h8) begin
            if (tw_shift_reg[7:1] == DEV_ADDR) begin
              tw_state_reg <= TW_ACK;
              tw_low_reg   <= 1'b1;
              tw_rw_reg    <= tw_shift_reg[0];
            end else begin
              tw_state_reg <= TW_IDLE;
            end
          end
        end
        TW_WRITE: begin
          if (tw_cnt_reg == 4'h8) begin
            tw_state_reg <= TW_ACK;
            tw_low_reg   <= 1'b1;
            tw_first_reg <= 1'b0;
            tw_ptr_reg   <= tw_first_reg ? tw_shift_reg : tw_ptr_reg + 8'h1;
          end
        end
        TW_ACK, TW_RACK: begin
          tw_cnt_reg <= 4'h0;
          if (!tw_rw_reg) begin
            tw_state_reg <= (tw_state_reg == TW_ACK) ? TW_WRITE : TW_IDLE;
            tw_low_reg   <= 1'b0;
          end else begin
            tw_state_reg <= TW_READ;
            tw_shift_reg <= {rd_byte[6:0], 1'b0};
            tw_low_reg   <= ~rd_byte[7];
            tw_cnt_reg   <= 4'h1;
            tw_ptr_reg   <= tw_ptr_reg + 8'h1;
          end
        end
        TW_READ: begin
          if (tw_cnt_reg == 4'h8) begin
            tw_state_reg <= TW_RACK;
            tw_low_reg   <= 1'b0;
          end else begin
            tw_low_reg   <= ~tw_shift_reg[7];
            tw_shift_reg <= {tw_shift_reg[6:0], 1'b0};
            tw_cnt_reg   <= tw_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // The data pin is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe  = tw_low_reg;

  // ========================================================================
  // Plain configuration registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      apc_coarse_reg <= SAVED_APC_COARSE;
      apc_fine_reg   <= {6'h00, SAVED_APC_FINE};
      range_reg      <= 8'h00;
      src_supply_reg <= `LPC_RST_SRC_SUPPLY;
      mode_reg       <= `LPC_RST_TBL_MODE;
      rail_reg       <= 8'h00;
      tbl_waddr_reg  <= 8'h00;
      aux2_high_reg  <= `LPC_RST_AUX2_HIGH;
      aux2_low_reg   <= `LPC_RST_AUX2_LOW;
    end else if (wr_stb) begin
      unique case (wr_addr)
        `LPC_OFF_APC_COARSE: apc_coarse_reg <= tw_shift_reg;
        `LPC_OFF_APC_FINE:   apc_fine_reg   <= tw_shift_reg & 8'h83;
        `LPC_OFF_MOD_RANGE:  range_reg      <= tw_shift_reg & 8'h07;
        `LPC_OFF_SRC_SUPPLY: src_supply_reg <= tw_shift_reg;
        `LPC_OFF_TBL_MODE:   mode_reg       <= tw_shift_reg & 8'h03;
        `LPC_OFF_RAIL_SEL:   rail_reg       <= tw_shift_reg & 8'h01;
        `LPC_OFF_TBL_WADDR:  tbl_waddr_reg  <= tw_shift_reg & 8'h7f;
        `LPC_OFF_AUX2_HIGH:  aux2_high_reg  <= tw_shift_reg;
        `LPC_OFF_AUX2_LOW:   aux2_low_reg   <= tw_shift_reg;
        default: ;
      endcase
    end
  end

  // Table memory, loaded through the address and data window.
  always_ff @(posedge mclk) begin
    if (wr_stb && wr_addr == `LPC_OFF_TBL_WDATA) begin
      lut_mem[tbl_waddr_reg[6:0]] <= tw_shift_reg;
    end
  end

  // ========================================================================
  // Table pointer and value according to the two mode bits.
  logic        temp_index_enable, auto_value_enable;
  logic [15:0] idx_temp;
  assign temp_index_enable      = mode_reg[`LPC_BIT_TEMP_INDEX];
  assign auto_value_enable      = mode_reg[`LPC_BIT_AUTO_VALUE];
  assign idx_temp = src_supply_reg[`LPC_BIT_TEMP_SRC] ? result_reg[MON_AUX2] : result_reg[MON_TEMP];

  always_ff @(posedge mclk) begin
    if (rst) begin
      pointer_reg <= `LPC_TBL_FIRST;
      value_reg   <= 8'h00;
    end else begin
      if (auto_value_enable) begin
        pointer_reg <= temp_to_index(idx_temp[15:8]);
      end else if (temp_index_enable && wr_stb && wr_addr == `LPC_OFF_TBL_POINTER) begin
        pointer_reg <= tw_shift_reg | `LPC_TBL_FIRST;
      end
      if (temp_index_enable) begin
        value_reg <= lut_mem[pointer_reg[6:0]];
      end else if (wr_stb && wr_addr == `LPC_OFF_TBL_VALUE) begin
        value_reg <= tw_shift_reg;
      end
    end
  end

  // Value code, and range clamped at code 100, go registered to the modulation current source.
  always_ff @(posedge mclk) begin
    if (rst) begin
      modulation_drive <= 8'h00;
      modulation_range <= 3'h0;
    end else begin
      modulation_drive <= value_reg;
      modulation_range <= (range_reg[2:0] > 3'h4) ? 3'h4 : range_reg[2:0];
    end
  end

  // ========================================================================
  // Monitor sequencer with averaging.
  lpc_chan_e          chan_reg;
  logic               busy_reg;
  logic [4:0]         conv_cnt_reg;
  logic signed [17:0] acc_reg;
  logic signed [17:0] sample, acc_sum;
  logic signed [15:0] avg16;
  logic               last_conv;
  logic [15:0]        fmt;

  assign sample    = (chan_reg == MON_TEMP) ? 18'(signed'(adc_rsp.data)) : 18'({5'h00, adc_rsp.data});
  assign acc_sum   = acc_reg + sample;
  assign last_conv = (chan_reg == MON_TEMP) ? (conv_cnt_reg == 5'hf) : (conv_cnt_reg == 5'h7);
  assign avg16     = (chan_reg == MON_TEMP) ? 16'(acc_sum >>> 4) <<< 3 : 16'(acc_sum >>> 3) <<< 3;

  // Temperature clamps depend on which sensor indexes the table.
  always_comb begin
    fmt = avg16;
    if (chan_reg == MON_TEMP) begin
      if (src_supply_reg[`LPC_BIT_TEMP_SRC]) begin
        if (avg16 < signed'(`LPC_CLAMP_EXT_LO)) fmt = `LPC_CLAMP_EXT_LO;
        if (avg16 > signed'(`LPC_CLAMP_EXT_HI)) fmt = `LPC_CLAMP_EXT_HI;
      end else begin
        if (avg16 < signed'(`LPC_CLAMP_INT_LO)) fmt = `LPC_CLAMP_INT_LO;
        if (avg16 > signed'(`LPC_CLAMP_INT_HI)) fmt = `LPC_CLAMP_INT_HI;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      chan_reg     <= MON_TEMP;
      busy_reg     <= 1'b0;
      conv_cnt_reg <= 5'h00;
      acc_reg      <= 18'sh0;
    end else if (!busy_reg) begin
      busy_reg <= 1'b1;
    end else if (adc_rsp.done) begin
      busy_reg <= 1'b0;
      if (last_conv) begin
        conv_cnt_reg <= 5'h00;
        acc_reg      <= 18'sh0;
        chan_reg     <= next_chan(chan_reg, src_supply_reg);
      end else begin
        conv_cnt_reg <= conv_cnt_reg + 5'h1;
        acc_reg      <= acc_sum;
      end
    end
  end

  // Result store; a disabled supply channel holds no result.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 7; i++) begin
        result_reg[i] <= 16'h0000;
      end
    end else begin
      if (busy_reg && adc_rsp.done && last_conv) begin
        result_reg[chan_reg] <= fmt;
      end
      if (!src_supply_reg[`LPC_BIT_SUPPLY_EN]) begin
        result_reg[MON_SUPPLY] <= 16'h0000;
      end
    end
  end

  // Conversion request to the front end.
  always_comb begin
    adc_req.start = ~busy_reg & ~rst;
    adc_req.chan  = chan_reg;
    adc_req.rail  = rail_reg[0];
  end

  // ========================================================================
  // Second auxiliary tolerance flag on the interrupt pin.
  always_ff @(posedge mclk) begin
    if (rst) begin
      aux2_flag_reg <= 1'b0;
    end else begin
      aux2_flag_reg <= src_supply_reg[`LPC_BIT_AUX2_EN] && !src_supply_reg[`LPC_BIT_TEMP_SRC] &&
                       (result_reg[MON_AUX2][15:8] > aux2_high_reg ||
                        result_reg[MON_AUX2][15:8] < aux2_low_reg);
    end
  end

  assign interrupt_out = 1'b0;
  assign interrupt_oe  = aux2_flag_reg;

  // ========================================================================
  // Bias power loop with a ramped target.
  logic [9:0]        target_code, ramp_reg;
  logic [15:0]       tick_reg;
  logic [BIAS_W-1:0] bias_reg;
  logic              tick;

  assign target_code = {apc_coarse_reg, 2'b00} + {8'h00, apc_fine_reg[1:0]};
  assign tick        = (tick_reg == 16'(TICK_CYC - 1));

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_reg <= 16'h0000;
      ramp_reg <= 10'h000;
      bias_reg <= '0;
    end else begin
      tick_reg <= tick ? 16'h0000 : tick_reg + 16'h1;
      if (tick) begin
        if (ramp_reg < target_code) ramp_reg <= ramp_reg + 10'h1;
        else if (ramp_reg > target_code) ramp_reg <= ramp_reg - 10'h1;
        if (photodiode_feedback < ramp_reg && bias_reg != '1) begin
          bias_reg <= bias_reg + 1'b1;
        end else if (photodiode_feedback > ramp_reg && bias_reg != '0) begin
          bias_reg <= bias_reg - 1'b1;
        end
      end
    end
  end

  assign bias_drive         = bias_reg;
  assign feedback_direction = apc_fine_reg[`LPC_BIT_FB_DIR];

endmodule

// ===== src/lpc_pkg.sv
// ==========================================================================
// Types shared by the laser power control core.
package lpc_pkg;

  typedef enum logic [2:0] {
    MON_TEMP, MON_SUPPLY, MON_BIAS, MON_FEEDBACK, MON_RXPOWER, MON_AUX1, MON_AUX2
  } lpc_chan_e;

  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_ACK, TW_WRITE, TW_READ, TW_RACK
  } lpc_tw_state_e;

  typedef struct packed {
    logic      start;
    lpc_chan_e chan;
    logic      rail;
  } lpc_adc_req_s;

  typedef struct packed {
    logic        done;
    logic [12:0] data;
  } lpc_adc_rsp_s;

endpackage

// ===== src/lpc_regs.svh
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

// ==========================================================================
// Register offsets on the two-wire bus.
`define LPC_OFF_RESULT_BASE   8'h60
`define LPC_OFF_AUX_TEMP      8'h6a
`define LPC_OFF_APC_COARSE    8'h84
`define LPC_OFF_APC_FINE      8'h85
`define LPC_OFF_MOD_RANGE     8'h86
`define LPC_OFF_SRC_SUPPLY    8'h8b
`define LPC_OFF_TBL_POINTER   8'hb0
`define LPC_OFF_TBL_VALUE     8'hb1
`define LPC_OFF_TBL_MODE      8'hb2
`define LPC_OFF_RAIL_SEL      8'hdc
`define LPC_OFF_TBL_WADDR     8'he0
`define LPC_OFF_TBL_WDATA     8'he1
`define LPC_OFF_AUX2_HIGH     8'he2
`define LPC_OFF_AUX2_LOW      8'he3
`define LPC_OFF_FLAGS         8'he4

// ==========================================================================
// Field positions.
`define LPC_BIT_AUTO_VALUE    0
`define LPC_BIT_TEMP_INDEX    1
`define LPC_BIT_SUPPLY_EN     0
`define LPC_BIT_TEMP_SRC      1
`define LPC_BIT_AUX1_EN       2
`define LPC_BIT_AUX2_EN       3
`define LPC_BIT_FB_DIR        7

// ==========================================================================
// Reset values.
`define LPC_RST_TBL_MODE      8'h03
`define LPC_RST_SRC_SUPPLY    8'h0d
`define LPC_RST_AUX2_HIGH     8'hff
`define LPC_RST_AUX2_LOW      8'h00

// ==========================================================================
// Table addressing, temperature clamps and timing.
`define LPC_TBL_FIRST         8'h80
`define LPC_TBL_LAST          8'hc7
`define LPC_TEMP_MIN_DEG      -40
`define LPC_TEMP_MAX_DEG      102
`define LPC_CLAMP_EXT_LO      16'hd800
`define LPC_CLAMP_EXT_HI      16'h67f0
`define LPC_CLAMP_INT_LO      16'h8800
`define LPC_CLAMP_INT_HI      16'h7ff8
`define LPC_MCLK_PERIOD_PS    4000
`define LPC_APC_TICK_NS       1000
`define LPC_APC_TICK_CYCLES   ((`LPC_APC_TICK_NS * 1000) / `LPC_MCLK_PERIOD_PS)

`endif
